// File: verilog/rcim_cfg.svh
// offsets, field positions, reset values and timing counts of the remote input mapper
`ifndef RCIM_CFG_SVH
`define RCIM_CFG_SVH

// clock rate and times
`define RCIM_CLK_KHZ  50000
`define RCIM_DEB_US   10
`define RCIM_DEB_CYC  ((`RCIM_DEB_US * `RCIM_CLK_KHZ + 999) / 1000)
`define RCIM_STEP_MS  500
`define RCIM_STEP_CYC (`RCIM_STEP_MS * `RCIM_CLK_KHZ)

// register byte addresses
`define RCIM_A_CTRL   12'h000
`define RCIM_A_STAT   12'h004
`define RCIM_A_CFG    12'h040

// configuration word fields
`define RCIM_F_FUNC   3:0
`define RCIM_F_MODE   7:4
`define RCIM_F_ARG    11:8
`define RCIM_F_ARG_LO 8

// status word fields (pin levels occupy the low bits)
`define RCIM_S_REN    16
`define RCIM_S_EXC_B  17
`define RCIM_S_AUTO   18

// reset values
`define RCIM_CFG_RST0 12'h011
`define RCIM_CFG_RST1 12'h031
`define RCIM_CFG_RST2 12'h014
`define RCIM_CFG_RST3 12'h114
`define RCIM_CFG_RST4 12'h045
`define RCIM_CFG_RST5 12'h096
`define RCIM_CFG_RST6 12'h0B7
`define RCIM_REN_RST  1'b0
`define RCIM_EXC_RST  1'b0
`define RCIM_AUTO_RST 1'b0
`define RCIM_LVL_RST  1'b1

`endif

// File: verilog/rcim_pkg.sv
// types and the polarity decoder of the remote input mapper
package rcim_pkg;

  typedef enum logic [3:0] {
    FN_NONE, FN_RF, FN_RESET, FN_HOST, FN_EXC, FN_AUTO, FN_INC, FN_DEC, FN_PRESET
  } rcim_func_t;

  typedef enum logic [3:0] {
    MD_RISE_ON, MD_FALL_ON, MD_RISE_OFF, MD_FALL_OFF, MD_FALL_TOG, MD_RISE_TOG,
    MD_RON_FOFF, MD_FON_ROFF, MD_HIGH_INC, MD_LOW_INC, MD_HIGH_DEC, MD_LOW_DEC
  } rcim_mode_t;

  typedef struct packed {
    logic on_r;
    logic on_f;
    logic off_r;
    logic off_f;
    logic tog;
  } rcim_edge_t;

  typedef enum logic {PW_IDLE, PW_HOLD} rcim_pw_t;

  function automatic rcim_edge_t mode_dec(input logic [3:0] m);
    rcim_edge_t e;
    e = '0;
    case (m)
      MD_RISE_ON:  e.on_r = 1'b1;
      MD_FALL_ON:  e.on_f = 1'b1;
      MD_RISE_OFF: e.off_r = 1'b1;
      MD_FALL_OFF: e.off_f = 1'b1;
      MD_FALL_TOG: begin
        e.on_f = 1'b1;
        e.tog  = 1'b1;
      end
      MD_RISE_TOG: begin
        e.on_r = 1'b1;
        e.tog  = 1'b1;
      end
      MD_RON_FOFF, MD_HIGH_INC, MD_HIGH_DEC: begin
        e.on_r  = 1'b1;
        e.off_f = 1'b1;
      end
      MD_FON_ROFF, MD_LOW_INC, MD_LOW_DEC: begin
        e.on_f  = 1'b1;
        e.off_r = 1'b1;
      end
      default: e = '0;
    endcase
    return e;
  endfunction

endpackage

// File: verilog/rcim_debounce.sv
// one remote input: synchroniser and stable-time filter
`timescale 1ns/1ps
`include "rcim_cfg.svh"
module rcim_debounce #(
  parameter int CYC = 500
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);
  localparam int CW = $clog2(CYC + 1);

  if (CYC < 2) begin : g_bad
    $error("rcim_debounce: CYC must be at least 2");
  end

  logic          s1;
  logic          s2;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_level;

  // level follows the pin only after it stayed put for CYC cycles
  always_comb begin
    next_cnt   = '0;
    next_level = level_o;
    if (s2 != level_o) begin
      if (cnt == CW'(CYC - 1)) begin
        next_level = s2;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1      <= `RCIM_LVL_RST;
      s2      <= `RCIM_LVL_RST;
      cnt     <= '0;
      level_o <= `RCIM_LVL_RST;
    end else begin
      s1      <= pin_i;
      s2      <= s1;
      cnt     <= next_cnt;
      level_o <= next_level;
    end
  end

  a_deb_settle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(level_o) |-> ($past(cnt) == CW'(CYC - 1)) && ($past(s2) == level_o))
    else $error("filtered level changed before the stable time");
endmodule

// File: verilog/rcim_top.sv
// remote control input mapper: pin gating, command mapping and axi4-lite registers
`timescale 1ns/1ps
`include "rcim_cfg.svh"
module rcim_top
  import rcim_pkg::*;
#(
  parameter int N_IN     = 10,
  parameter int STEP_CYC = `RCIM_STEP_CYC
) (
  // clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  // remote input pins
  input  wire logic [N_IN-1:0] remote_in_i,
  // front panel
  input  wire logic            panel_ren_we_i,
  input  wire logic            panel_ren_i,
  input  wire logic            panel_cfg_we_i,
  input  wire logic [3:0]      panel_cfg_idx_i,
  input  wire logic [11:0]     panel_cfg_dat_i,
  output logic      [11:0]     panel_cfg_o,
  output logic      [N_IN-1:0] pin_level_o,
  output logic                 remote_en_o,
  // transmitter commands
  output logic                 rf_on_o,
  output logic                 rf_off_o,
  output logic                 sys_reset_o,
  output logic                 host_reboot_o,
  output logic                 exc_b_o,
  output logic                 auto_chg_o,
  output logic                 pwr_up_o,
  output logic                 pwr_dn_o,
  output logic                 preset_ld_o,
  output logic      [3:0]      preset_idx_o,
  // axi4-lite slave
  input  wire logic [11:0]     s_axi_awaddr_i,
  input  wire logic            s_axi_awvalid_i,
  output logic                 s_axi_awready_o,
  input  wire logic [31:0]     s_axi_wdata_i,
  input  wire logic [3:0]      s_axi_wstrb_i,
  input  wire logic            s_axi_wvalid_i,
  output logic                 s_axi_wready_o,
  output logic      [1:0]      s_axi_bresp_o,
  output logic                 s_axi_bvalid_o,
  input  wire logic            s_axi_bready_i,
  input  wire logic [11:0]     s_axi_araddr_i,
  input  wire logic            s_axi_arvalid_i,
  output logic                 s_axi_arready_o,
  output logic      [31:0]     s_axi_rdata_o,
  output logic      [1:0]      s_axi_rresp_o,
  output logic                 s_axi_rvalid_o,
  input  wire logic            s_axi_rready_i
);
  localparam int         DEB = `RCIM_DEB_CYC;
  localparam int         CW  = $clog2(STEP_CYC);
  localparam logic [1:0] OKAY   = 2'h0;
  localparam logic [1:0] SLVERR = 2'h2;

  if (N_IN < 1 || N_IN > 16 || STEP_CYC < 2) begin : g_bad
    $error("rcim_top: N_IN must be 1..16 and STEP_CYC at least 2");
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // configuration word of input i after reset
  function automatic logic [11:0] cfg_rst(input int i);
    case (i)
      0:       return `RCIM_CFG_RST0;
      1:       return `RCIM_CFG_RST1;
      2:       return `RCIM_CFG_RST2;
      3:       return `RCIM_CFG_RST3;
      4:       return `RCIM_CFG_RST4;
      5:       return `RCIM_CFG_RST5;
      6:       return `RCIM_CFG_RST6;
      default: return 12'h000;
    endcase
  endfunction

  // bit 4 flags a configuration word, bits 3:0 give its input number
  function automatic logic [4:0] reg_dec(input logic [11:0] a);
    logic [4:0] r;
    r = {1'b0, a[5:2]};
    if (a[11:6] == 6'(`RCIM_A_CFG >> 6) && a[1:0] == 2'h0 && 32'(a[5:2]) < N_IN) begin
      r[4] = 1'b1;
    end
    return r;
  endfunction

  logic [N_IN-1:0] lvl;
  logic [N_IN-1:0] prev;
  logic [N_IN-1:0] tog;
  logic [N_IN-1:0] next_prev;
  logic [N_IN-1:0] next_tog;
  logic [N_IN-1:0] on_evt;
  logic [N_IN-1:0] off_evt;
  logic [N_IN-1:0] held;
  logic [11:0]     cfg      [N_IN];
  logic [11:0]     next_cfg [N_IN];

  for (genvar g = 0; g < N_IN; g++) begin : g_deb
    rcim_debounce #(.CYC(DEB)) u_deb (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (remote_in_i[g]),
      .level_o   (lvl[g])
    );
  end

  // edge, toggle and level qualification of every input
  always_comb begin : c_evt
    rcim_edge_t ed;
    logic       rise;
    logic       fall;
    logic       qual;
    logic       act;
    ed        = '0;
    rise      = 1'b0;
    fall      = 1'b0;
    qual      = 1'b0;
    act       = 1'b0;
    next_prev = lvl;
    next_tog  = tog;
    on_evt    = '0;
    off_evt   = '0;
    held      = '0;
    for (int i = 0; i < N_IN; i++) begin
      ed   = mode_dec(cfg[i][`RCIM_F_MODE]);
      rise = lvl[i] & ~prev[i];
      fall = ~lvl[i] & prev[i];
      qual = (ed.on_r & rise) | (ed.on_f & fall);
      act  = remote_en_o && cfg[i][`RCIM_F_FUNC] != FN_NONE;
      if (act) begin
        held[i] = ed.on_f ? ~lvl[i] : lvl[i];
        if (ed.tog) begin
          on_evt[i]  = qual & (tog[i] == ed.on_f);
          off_evt[i] = qual & (tog[i] != ed.on_f);
          if (qual) begin
            next_tog[i] = ~tog[i];
          end
        end else begin
          on_evt[i]  = qual;
          off_evt[i] = (ed.off_r & rise) | (ed.off_f & fall);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev <= {N_IN{`RCIM_LVL_RST}};
      tog  <= '0;
    end else begin
      prev <= next_prev;
      tog  <= next_tog;
    end
  end

  // one-shot commands and latched selections
  logic       next_rf_on;
  logic       next_rf_off;
  logic       next_sys_reset;
  logic       next_host;
  logic       next_exc_b;
  logic       next_auto;
  logic       next_pre_ld;
  logic [3:0] next_pre_idx;

  always_comb begin : c_cmd
    logic flip;
    flip           = 1'b0;
    next_rf_on     = 1'b0;
    next_rf_off    = 1'b0;
    next_sys_reset = 1'b0;
    next_host      = 1'b0;
    next_exc_b     = exc_b_o;
    next_pre_ld    = 1'b0;
    next_pre_idx   = preset_idx_o;
    // walk downwards so the lowest-numbered input has the last word
    for (int i = N_IN - 1; i >= 0; i--) begin
      case (rcim_func_t'(cfg[i][`RCIM_F_FUNC]))
        FN_RF: begin
          next_rf_on  = next_rf_on | on_evt[i];
          next_rf_off = next_rf_off | off_evt[i];
        end
        FN_RESET: next_sys_reset = next_sys_reset | on_evt[i];
        FN_HOST:  next_host = next_host | on_evt[i];
        FN_EXC: begin
          if (on_evt[i]) begin
            next_exc_b = cfg[i][`RCIM_F_ARG_LO];
          end
        end
        FN_AUTO:  flip = flip | on_evt[i] | off_evt[i];
        FN_PRESET: begin
          if (on_evt[i]) begin
            next_pre_ld  = 1'b1;
            next_pre_idx = cfg[i][`RCIM_F_ARG];
          end
        end
        default: ;
      endcase
    end
    if (next_rf_off) begin
      next_rf_on = 1'b0;
    end
    next_auto = flip ? ~auto_chg_o : auto_chg_o;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rf_on_o       <= 1'b0;
      rf_off_o      <= 1'b0;
      sys_reset_o   <= 1'b0;
      host_reboot_o <= 1'b0;
      exc_b_o       <= `RCIM_EXC_RST;
      auto_chg_o    <= `RCIM_AUTO_RST;
      preset_ld_o   <= 1'b0;
      preset_idx_o  <= 4'h0;
    end else begin
      rf_on_o       <= next_rf_on;
      rf_off_o      <= next_rf_off;
      sys_reset_o   <= next_sys_reset;
      host_reboot_o <= next_host;
      exc_b_o       <= next_exc_b;
      auto_chg_o    <= next_auto;
      preset_ld_o   <= next_pre_ld;
      preset_idx_o  <= next_pre_idx;
    end
  end

  // power step with hold-to-repeat
  rcim_pw_t        pw_st;
  rcim_pw_t        next_pw_st;
  logic [3:0]      pw_idx;
  logic [3:0]      next_pw_idx;
  logic [CW-1:0]   pw_cnt;
  logic [CW-1:0]   next_pw_cnt;
  logic [N_IN-1:0] pw_act;
  logic            win;
  logic            win_up;
  logic [3:0]      win_idx;
  logic            next_up;
  logic            next_dn;

  always_comb begin : c_pw
    logic step;
    step        = 1'b0;
    win         = 1'b0;
    win_up      = 1'b0;
    win_idx     = 4'h0;
    pw_act      = '0;
    next_pw_st  = pw_st;
    next_pw_idx = pw_idx;
    next_pw_cnt = pw_cnt;
    for (int i = N_IN - 1; i >= 0; i--) begin
      pw_act[i] = held[i] && (cfg[i][`RCIM_F_FUNC] == FN_INC || cfg[i][`RCIM_F_FUNC] == FN_DEC);
      if (pw_act[i]) begin
        win     = 1'b1;
        win_idx = 4'(i);
        win_up  = cfg[i][`RCIM_F_FUNC] == FN_INC;
      end
    end
    case (pw_st)
      PW_IDLE: begin
        if (win) begin
          step        = 1'b1;
          next_pw_st  = PW_HOLD;
          next_pw_idx = win_idx;
          next_pw_cnt = '0;
        end
      end
      PW_HOLD: begin
        if (!win) begin
          next_pw_st = PW_IDLE;
        end else if (win_idx != pw_idx) begin
          step        = 1'b1;
          next_pw_idx = win_idx;
          next_pw_cnt = '0;
        end else if (pw_cnt == CW'(STEP_CYC - 1)) begin
          step        = 1'b1;
          next_pw_cnt = '0;
        end else begin
          next_pw_cnt = pw_cnt + 1'b1;
        end
      end
      default: next_pw_st = PW_IDLE;
    endcase
    next_up = step & win_up;
    next_dn = step & ~win_up;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pw_st    <= PW_IDLE;
      pw_idx   <= 4'h0;
      pw_cnt   <= '0;
      pwr_up_o <= 1'b0;
      pwr_dn_o <= 1'b0;
    end else begin
      pw_st    <= next_pw_st;
      pw_idx   <= next_pw_idx;
      pw_cnt   <= next_pw_cnt;
      pwr_up_o <= next_up;
      pwr_dn_o <= next_dn;
    end
  end

  sequence s_hold_due;
    pw_st == PW_HOLD && win && win_idx == pw_idx && pw_cnt == CW'(STEP_CYC - 1);
  endsequence

  sequence s_one_step;
    (pwr_up_o ^ pwr_dn_o) ##1 !(pwr_up_o || pwr_dn_o);
  endsequence

  a_step_repeat: assert property (s_hold_due |=> s_one_step)
    else $error("held power input did not repeat its step on time");

  a_step_first: assert property ((pw_st == PW_IDLE && win) |=> (pwr_up_o ^ pwr_dn_o))
    else $error("new power activation gave no immediate step");

  a_step_lowest: assert property ((pwr_up_o || pwr_dn_o) |->
    ($past(pw_act) & ~({N_IN{1'b1}} << pw_idx)) == '0)
    else $error("power step obeyed a higher-numbered input");

  // configuration store, remote enable and panel views
  logic            wr_fire;
  logic [4:0]      wr_hit;
  logic [11:0]     aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            next_ren;
  logic [11:0]     next_panel_cfg;

  assign wr_hit = reg_dec(aw_addr);

  always_comb begin : c_cfg
    next_cfg = cfg;
    if (wr_fire && wr_hit[4]) begin
      if (w_strb[0]) begin
        next_cfg[wr_hit[3:0]][7:0] = w_data[7:0];
      end
      if (w_strb[1]) begin
        next_cfg[wr_hit[3:0]][11:8] = w_data[11:8];
      end
    end
    if (panel_cfg_we_i && 32'(panel_cfg_idx_i) < N_IN) begin
      next_cfg[panel_cfg_idx_i] = panel_cfg_dat_i;
    end
    next_ren       = panel_ren_we_i ? panel_ren_i : remote_en_o;
    next_panel_cfg = 12'h000;
    if (32'(panel_cfg_idx_i) < N_IN) begin
      next_panel_cfg = cfg[panel_cfg_idx_i];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_IN; i++) begin
        cfg[i] <= cfg_rst(i);
      end
      remote_en_o <= `RCIM_REN_RST;
      panel_cfg_o <= 12'h000;
      pin_level_o <= {N_IN{`RCIM_LVL_RST}};
    end else begin
      cfg         <= next_cfg;
      remote_en_o <= next_ren;
      panel_cfg_o <= next_panel_cfg;
      pin_level_o <= lvl;
    end
  end

  a_ren_panel_only: assert property ($changed(remote_en_o) |-> $past(panel_ren_we_i))
    else $error("remote enable changed without a panel write");

  a_gate_local: assert property (!remote_en_o |=>
    !(rf_on_o || rf_off_o || sys_reset_o || host_reboot_o || preset_ld_o || $changed(auto_chg_o)))
    else $error("command issued while in local-only control");

  a_auto_cause: assert property ($changed(auto_chg_o) |-> $past(remote_en_o) && $past(|(on_evt | off_evt)))
    else $error("auto changeover flipped without an activation");

  // axi4-lite slave
  logic        aw_full;
  logic        w_full;
  logic        next_aw_full;
  logic        next_w_full;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] status;

  assign wr_fire = aw_full && w_full && !s_axi_bvalid_o;

  always_comb begin : c_axi
    logic [4:0] rh;
    rh           = reg_dec(s_axi_araddr_i);
    status       = 32'h0000_0000;
    status[N_IN-1:0]     = lvl;
    status[`RCIM_S_REN]  = remote_en_o;
    status[`RCIM_S_EXC_B] = exc_b_o;
    status[`RCIM_S_AUTO] = auto_chg_o;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid_o && !s_axi_bready_i;
    next_bresp   = s_axi_bresp_o;
    next_rvalid  = s_axi_rvalid_o && !s_axi_rready_i;
    next_rresp   = s_axi_rresp_o;
    next_rdata   = s_axi_rdata_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit[4] ? OKAY : SLVERR;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp  = OKAY;
      if (s_axi_araddr_i == `RCIM_A_CTRL) begin
        next_rdata = {31'h0000_0000, remote_en_o};
      end else if (s_axi_araddr_i == `RCIM_A_STAT) begin
        next_rdata = status;
      end else if (rh[4]) begin
        next_rdata = {20'h0_0000, cfg[rh[3:0]]};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      aw_full         <= 1'b0;
      w_full          <= 1'b0;
      aw_addr         <= 12'h000;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= OKAY;
      s_axi_rdata_o   <= 32'h0000_0000;
    end else begin
      aw_full         <= next_aw_full;
      w_full          <= next_w_full;
      aw_addr         <= next_aw_addr;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      s_axi_awready_o <= !next_aw_full;
      s_axi_wready_o  <= !next_w_full;
      s_axi_bvalid_o  <= next_bvalid;
      s_axi_bresp_o   <= next_bresp;
      s_axi_arready_o <= !next_rvalid;
      s_axi_rvalid_o  <= next_rvalid;
      s_axi_rresp_o   <= next_rresp;
      s_axi_rdata_o   <= next_rdata;
    end
  end

  a_ctrl_refused: assert property ((wr_fire && aw_addr == `RCIM_A_CTRL) |=>
    s_axi_bvalid_o && s_axi_bresp_o == SLVERR && $stable(remote_en_o))
    else $error("bus write to remote enable was not refused");

  a_rf_pulse: assert property (rf_on_o |-> !rf_off_o ##1 !rf_on_o)
    else $error("rf on command not a single clean pulse");
endmodule

// File: verification/rcim_remote_unit.sv
// model of the remote control unit that drives the input pins
`timescale 1ns/1ps
module rcim_remote_unit #(
  parameter int HOLD = 520
) (
  // clock
  input  wire logic       ref_clk_i,
  // wanted levels and driven pins
  input  wire logic [9:0] lvl_i,
  output logic      [9:0] pins_o
);
  int cnt = 0;
  initial pins_o = 10'h3ff;
  // a new level is taken only once the last one has stood long enough
  always @(posedge ref_clk_i) begin
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (lvl_i != pins_o) begin
      pins_o <= lvl_i;
      cnt    <= HOLD;
    end
  end
endmodule

// File: verification/testbench.sv
// self-checking bench of the remote input mapper
`timescale 1ns/1ps
module testbench;
  import rcim_pkg::*;
  localparam int STP = 40;
  logic        ref_clk_i = 0;
  logic        rst_n_i = 0;
  logic [9:0]  lvl = 10'h3ff;
  logic [9:0]  pins;
  logic [9:0]  plev;
  logic        ren_we = 0;
  logic        ren = 0;
  logic        cfg_we = 0;
  logic [3:0]  cfg_idx = 0;
  logic [11:0] cfg_dat = 0;
  logic [11:0] pcfg;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic [31:0] rnd = 32'h2a7b_1639;
  logic [3:0]  pidx;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [6:0]  pulse;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ren_o, exc_b, auto, awready, wready, bvalid, arready, rvalid;
  int          cnt [7];
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;

  rcim_remote_unit i_rcim_remote_unit (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .pins_o(pins));
  rcim_top #(.STEP_CYC(STP)) i_rcim_top (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .remote_in_i(pins),
    .panel_ren_we_i(ren_we), .panel_ren_i(ren), .panel_cfg_we_i(cfg_we),
    .panel_cfg_idx_i(cfg_idx), .panel_cfg_dat_i(cfg_dat), .panel_cfg_o(pcfg),
    .pin_level_o(plev), .remote_en_o(ren_o), .rf_on_o(pulse[0]), .rf_off_o(pulse[1]),
    .sys_reset_o(pulse[2]), .host_reboot_o(pulse[3]), .exc_b_o(exc_b),
    .auto_chg_o(auto), .pwr_up_o(pulse[4]), .pwr_dn_o(pulse[5]),
    .preset_ld_o(pulse[6]), .preset_idx_o(pidx),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  always #10 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int nstep(input int h);
    return h / STP + 1;
  endfunction

  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // one low pulse on a pin, each level held past the filter time
  task automatic drop(input int i);
    lvl[i] <= 1'b0;
    wt(530);
    lvl[i] <= 1'b1;
    wt(530);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge ref_clk_i);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 7; k++) if (pulse[k] === 1'b1) cnt[k] <= cnt[k] + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    wt(10);
    rst_n_i <= 1'b1;
    wt(2);
    chk(exc_b, 0);
    chk(auto, 0);
    chk(plev, 10'h3ff);
    drop(0);
    chk(cnt[0], 0);
    $display("gate done");
    ren_we <= 1'b1;
    ren <= 1'b1;
    @(posedge ref_clk_i) ren_we <= 1'b0;
    axw(12'h000, 0, r);
    chk(r, 2);
    axr(12'h000, d, r);
    chk(d[0], 1);
    chk(ren_o, 1);
    axr(12'h040, d, r);
    chk(d, 32'h11);
    axr(12'h100, d, r);
    chk(r, 2);
    drop(0);
    drop(1);
    chk(cnt[0], 1);
    chk(cnt[1], 1);
    drop(3);
    chk(exc_b, 1);
    drop(2);
    chk(exc_b, 0);
    drop(4);
    chk(auto, 1);
    drop(4);
    chk(auto, 0);
    $display("commands done");
    lvl[6:5] <= 2'b00;
    wt(620);
    lvl[6:5] <= 2'b11;
    wt(600);
    chk(cnt[4], nstep(620));
    chk(cnt[5], 0);
    lvl[6] <= 1'b0;
    wt(540);
    lvl[6] <= 1'b1;
    wt(600);
    chk(cnt[5], nstep(540));
    $display("power done");
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      lvl[9:7] <= (k == 4) ? 3'b111 : rnd[2:0];
      wt(530);
      chk(plev, {lvl[9:7], 7'h7f});
    end
    chk(cnt[2] + cnt[3] + cnt[6], 0);
    cfg_idx <= 4'd7;
    cfg_dat <= 12'h518;
    cfg_we <= 1'b1;
    @(posedge ref_clk_i) cfg_we <= 1'b0;
    axr(12'h05c, d, r);
    chk(d, 32'h518);
    chk(pcfg, 12'h518);
    axw(12'h060, 32'h012, r);
    axw(12'h064, 32'h013, r);
    chk(r, 0);
    drop(7);
    chk(pidx, 5);
    chk(cnt[6], 1);
    drop(8);
    chk(cnt[2], 1);
    drop(9);
    chk(cnt[3], 1);
    axw(12'h060, 32'h002, r);
    chk(r, 0);
    lvl[8] <= 1'b0;
    wt(530);
    chk(cnt[2], 1);
    lvl[8] <= 1'b1;
    wt(530);
    chk(cnt[2], 2);
    $display("config done");
    close_out();
  end
endmodule
